// ---- core/ccr_regs.sv ----
// Per-channel codec control register bank with an APB slave port.
// Assumes pclk at 10 MHz, a zero-wait APB master, and asynchronous
// pin inputs for the line pins, real-time bits and status inputs.
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary neutral value
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CCR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Line I/O pins, split into input, output and enable
  input  wire logic [CCR_NPINS-1:0]  line_io_in,
  output logic      [CCR_NPINS-1:0]  line_io_out,
  output logic      [CCR_NPINS-1:0]  line_io_oe,
  // Real-time input bits and interrupt
  input  wire logic [CCR_NRT-1:0]    rt_in,
  output logic                       irq_n,
  // Status inputs from the channel and clock logic
  input  wire logic                  channel_active_in,
  input  wire logic                  clock_sync_lost_in,
  // Coding and coefficient source controls
  output logic                       linear_code_select,
  output logic                       companding_law_select,
  output logic [5:0]                 coef_source,
  // Path controls
  output logic                       tx_path_cutoff,
  output logic                       rx_path_cutoff,
  output logic                       balance_filter_enable,
  output logic                       tx_highpass_bypass,
  output logic                       rx_extra_loss,
  output logic                       tx_irq_arm,
  output logic                       slot_loopback,
  output logic                       full_digital_loopback,
  output logic                       rx_1khz_sig_gen,
  // Applied gain coefficients and decoded terms
  output logic [15:0]                tx_gain_applied,
  output logic [15:0]                rx_gain_applied,
  output logic [3:0]                 tx_gain_sign_neg,
  output logic [11:0]                tx_gain_exponent,
  output logic [3:0]                 rx_gain_sign_neg,
  output logic [11:0]                rx_gain_exponent
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [CCR_NPINS-1:0] dir_q;        // Pin direction bits
  logic [CCR_NPINS-1:0] pin_data_q;   // Latched pin data
  logic [7:0]           opfunc_q;     // Operating functions
  logic [7:0]           imask_q;      // Input change mask
  logic [7:0]           opcond_q;     // Operating conditions
  logic [15:0]          tx_gain_q;    // Programmed transmit gain
  logic [15:0]          rx_gain_q;    // Programmed receive gain
  logic [7:0]           rt_stable;    // Debounced real-time bits
  logic [7:0]           rt_prev_q;    // Previous real-time sample
  logic                 irq_pend_q;   // Interrupt pending flag
  logic [CCR_NPINS-1:0] pin_stable;   // Filtered line pin levels
  logic [1:0]           stat_stable;  // Filtered status inputs
  logic [31:0]          prdata_q;     // Registered read data
  logic                 pslverr_q;    // Registered error answer
  logic                 setup_ph;     // APB setup cycle
  logic                 access_ph;    // APB access cycle
  logic                 wr_en;        // Write takes effect
  logic                 rd_clear;     // Clearing real-time read
  logic                 rt_event;     // Unmasked real-time change
  logic [7:0]           wr_idx;       // Decoded register index
  logic                 wr_hit;       // Address is a mapped register

  // ==========================================================
  // Address decode helpers
  // ==========================================================
  // Turns a byte address into a register index, ignoring the low two bits
  function automatic logic [7:0] addr_index(input logic [CCR_ADDR_W-1:0] a);
    addr_index = a[9:2];
  endfunction

  // True when the byte address is a mapped register
  function automatic logic addr_mapped(input logic [CCR_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'b00 || a[CCR_ADDR_W-1:10] != '0) begin
      addr_mapped = 1'b0;
    end else begin
      addr_mapped = (idx == CCR_IDX_PIN_DATA) || (idx == CCR_IDX_DIR_STAT) ||
                    (idx == CCR_IDX_OPFUNC)   || (idx == CCR_IDX_IMASK)    ||
                    (idx == CCR_IDX_OPCOND)   || (idx == CCR_IDX_REVISION) ||
                    (idx == CCR_IDX_TX_GAIN)  || (idx == CCR_IDX_RX_GAIN)  ||
                    (idx == CCR_IDX_RT_KEEP)  || (idx == CCR_IDX_RT_CLEAR);
    end
  endfunction

  // ==========================================================
  // APB phase decode
  // ==========================================================
  // Zero-wait slave: answer data is ready by the access cycle
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_idx    = addr_index(paddr);
  assign wr_hit    = addr_mapped(paddr);
  assign wr_en     = access_ph & pwrite & wr_hit;
  assign rd_clear  = access_ph & ~pwrite & wr_hit & (wr_idx == CCR_IDX_RT_CLEAR);
  assign pready    = access_ph;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q & access_ph;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Real-time bits; the agreement filter is their debounce
  ccr_pin_sync #(
    .WIDTH   (CCR_NRT),
    .RST_VAL (CCR_RST_RT)
  ) u_rt_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (rt_in),
    .stable_q (rt_stable)
  );

  // Line pin levels, read back for pins set as inputs
  ccr_pin_sync #(
    .WIDTH   (CCR_NPINS),
    .RST_VAL (5'h00)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (line_io_in),
    .stable_q (pin_stable)
  );

  // Channel active and clock sync status
  ccr_pin_sync #(
    .WIDTH   (2),
    .RST_VAL (2'b00)
  ) u_stat_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   ({channel_active_in, clock_sync_lost_in}),
    .stable_q (stat_stable)
  );

  // ==========================================================
  // Pin direction and pin data
  // ==========================================================
  // Status bits of the direction word are not stored, writes ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= CCR_RST_DIR;
    end else if (wr_en && wr_idx == CCR_IDX_DIR_STAT) begin
      dir_q <= pwdata[CCR_NPINS-1:0];
    end
  end

  // Data is latched for every pin, even those set as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_data_q <= CCR_RST_PIN_DATA;
    end else if (wr_en && wr_idx == CCR_IDX_PIN_DATA) begin
      pin_data_q <= pwdata[CCR_NPINS-1:0];
    end
  end

  // Only pins set as outputs are driven
  assign line_io_out = pin_data_q;
  assign line_io_oe  = dir_q;

  // ==========================================================
  // Operating functions, mask and conditions
  // ==========================================================
  // Coding law and coefficient source selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opfunc_q <= CCR_RST_OPFUNC;
    end else if (wr_en && wr_idx == CCR_IDX_OPFUNC) begin
      opfunc_q <= pwdata[7:0];
    end
  end

  // Mask resets to all masked so no stray interrupt after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= CCR_RST_IMASK;
    end else if (wr_en && wr_idx == CCR_IDX_IMASK) begin
      imask_q <= pwdata[7:0];
    end
  end

  // Path cutoffs, loopbacks and test tone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcond_q <= CCR_RST_OPCOND;
    end else if (wr_en && wr_idx == CCR_IDX_OPCOND) begin
      opcond_q <= pwdata[7:0];
    end
  end

  // Control outputs straight from the stored bits
  assign linear_code_select    = opfunc_q[CCR_BIT_LINEAR];
  assign companding_law_select = opfunc_q[CCR_BIT_MULAW];
  assign coef_source           = opfunc_q[5:0];
  assign tx_path_cutoff        = opcond_q[CCR_BIT_TX_CUT];
  assign rx_path_cutoff        = opcond_q[CCR_BIT_RX_CUT];
  assign tx_highpass_bypass    = opcond_q[CCR_BIT_HPF_BYP];
  assign rx_extra_loss         = opcond_q[CCR_BIT_RX_LOSS];
  assign tx_irq_arm            = opcond_q[CCR_BIT_TX_ARM];
  assign slot_loopback         = opcond_q[CCR_BIT_SLOT_LB];
  assign full_digital_loopback = opcond_q[CCR_BIT_FDL];
  assign rx_1khz_sig_gen       = opcond_q[CCR_BIT_TONE];

  // Balance filter off whenever the receive path is cut
  assign balance_filter_enable = ~opcond_q[CCR_BIT_RX_CUT];

  // ==========================================================
  // Gain coefficients
  // ==========================================================
  // Programmed store; the fixed defaults live only in the package
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_gain_q <= CCR_RST_TX_GAIN;
      rx_gain_q <= CCR_RST_RX_GAIN;
    end else if (wr_en && wr_idx == CCR_IDX_TX_GAIN) begin
      tx_gain_q <= pwdata[15:0];
    end else if (wr_en && wr_idx == CCR_IDX_RX_GAIN) begin
      rx_gain_q <= pwdata[15:0];
    end
  end

  // Source bit picks programmed or fixed default set
  assign tx_gain_applied = opfunc_q[CCR_BIT_SRC_TXG] ? tx_gain_q : CCR_ROM_TX_GAIN;
  assign rx_gain_applied = opfunc_q[CCR_BIT_SRC_RXG] ? rx_gain_q : CCR_ROM_RX_GAIN;

  // Transmit term decode; the unity term is added downstream
  ccr_coef_decode u_tx_dec (
    .coef     (tx_gain_applied),
    .sign_neg (tx_gain_sign_neg),
    .exponent (tx_gain_exponent)
  );

  // Receive term decode, no unity term
  ccr_coef_decode u_rx_dec (
    .coef     (rx_gain_applied),
    .sign_neg (rx_gain_sign_neg),
    .exponent (rx_gain_exponent)
  );

  // ==========================================================
  // Real-time change interrupt
  // ==========================================================
  // Previous sample for change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_prev_q <= CCR_RST_RT;
    end else begin
      rt_prev_q <= rt_stable;
    end
  end

  // Masked bits cannot raise the flag
  assign rt_event = |((rt_stable ^ rt_prev_q) & ~imask_q);

  // A change in the clearing read's own cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_q <= 1'b0;
    end else if (rt_event) begin
      irq_pend_q <= 1'b1;
    end else if (rd_clear) begin
      irq_pend_q <= 1'b0;
    end
  end

  // Active-low interrupt, high while nothing is pending
  assign irq_n = ~irq_pend_q;

  // ==========================================================
  // Read data and error answer
  // ==========================================================
  // Captured in the setup cycle so prdata comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      pslverr_q <= ~wr_hit;
      prdata_q  <= 32'h0000_0000;
      if (!pwrite && wr_hit) begin
        unique case (wr_idx)
          CCR_IDX_DIR_STAT: begin
            // Sync lost is shown whatever the channel enable
            prdata_q[CCR_NPINS-1:0]     <= dir_q;
            prdata_q[CCR_BIT_CH_ACTIVE] <= stat_stable[1];
            prdata_q[CCR_BIT_SYNC_LOST] <= stat_stable[0];
          end
          CCR_IDX_PIN_DATA: begin
            // Inputs read the pin, outputs read the latch
            prdata_q[CCR_NPINS-1:0] <= (pin_data_q & dir_q) | (pin_stable & ~dir_q);
          end
          CCR_IDX_OPFUNC:   prdata_q[7:0]  <= opfunc_q;
          CCR_IDX_IMASK:    prdata_q[7:0]  <= imask_q;
          CCR_IDX_OPCOND:   prdata_q[7:0]  <= opcond_q;
          CCR_IDX_REVISION: prdata_q[7:0]  <= REVISION_CODE;
          CCR_IDX_TX_GAIN:  prdata_q[15:0] <= tx_gain_q;
          CCR_IDX_RX_GAIN:  prdata_q[15:0] <= rx_gain_q;
          CCR_IDX_RT_KEEP:  prdata_q[7:0]  <= rt_stable;
          CCR_IDX_RT_CLEAR: prdata_q[7:0]  <= rt_stable;
          default:          prdata_q       <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- include/ccr_pkg.sv ----
// Constants shared by the per-channel codec control register bank.
// Assumes a 32-bit APB slave port with byte addresses on paddr.
package ccr_pkg;

  // ==========================================================
  // Register indices (printed offsets); byte address is 4x index
  // ==========================================================
  localparam logic [7:0] CCR_IDX_PIN_DATA = 8'h52; // Latched line pin data
  localparam logic [7:0] CCR_IDX_DIR_STAT = 8'h54; // line_io_direction_status
  localparam logic [7:0] CCR_IDX_OPFUNC   = 8'h60; // operating_functions
  localparam logic [7:0] CCR_IDX_IMASK    = 8'h6C; // input_change_interrupt_mask
  localparam logic [7:0] CCR_IDX_OPCOND   = 8'h70; // operating_conditions
  localparam logic [7:0] CCR_IDX_REVISION = 8'h73; // silicon_revision_code
  localparam logic [7:0] CCR_IDX_TX_GAIN  = 8'h80; // transmit_gain_coefficient
  localparam logic [7:0] CCR_IDX_RX_GAIN  = 8'h82; // receive_gain_coefficient
  localparam logic [7:0] CCR_IDX_RT_KEEP  = 8'h4D; // Real-time data, keep pending
  localparam logic [7:0] CCR_IDX_RT_CLEAR = 8'h4F; // Real-time data, clear pending

  // ==========================================================
  // Bus geometry
  // ==========================================================
  localparam int CCR_ADDR_W = 12;  // Covers 4 x 0x82 plus the low byte lanes
  localparam int CCR_NPINS  = 5;   // Line I/O pins
  localparam int CCR_NRT    = 8;   // Real-time input bits (A and B, four channels)

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CCR_BIT_CH_ACTIVE = 6;  // channel_active_flag
  localparam int CCR_BIT_SYNC_LOST = 5;  // clock_sync_lost
  localparam int CCR_BIT_LINEAR    = 7;  // linear_code_select
  localparam int CCR_BIT_MULAW     = 6;  // companding_law_select
  localparam int CCR_BIT_SRC_RXG   = 5;  // rx_gain_coef_source
  localparam int CCR_BIT_SRC_TXG   = 4;  // tx_gain_coef_source
  localparam int CCR_BIT_SRC_X     = 3;  // tx_shaping_coef_source
  localparam int CCR_BIT_SRC_R     = 2;  // rx_shaping_coef_source
  localparam int CCR_BIT_SRC_Z     = 1;  // impedance_coef_source
  localparam int CCR_BIT_SRC_B     = 0;  // balance_coef_source
  localparam int CCR_BIT_TX_CUT    = 7;  // tx_path_cutoff
  localparam int CCR_BIT_RX_CUT    = 6;  // rx_path_cutoff
  localparam int CCR_BIT_HPF_BYP   = 5;  // tx_highpass_bypass
  localparam int CCR_BIT_RX_LOSS   = 4;  // rx_extra_loss
  localparam int CCR_BIT_TX_ARM    = 3;  // tx_irq_arm
  localparam int CCR_BIT_SLOT_LB   = 2;  // slot_loopback
  localparam int CCR_BIT_FDL       = 1;  // full_digital_loopback
  localparam int CCR_BIT_TONE      = 0;  // rx_1khz_sig_gen

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [4:0]  CCR_RST_DIR      = 5'h00;
  localparam logic [4:0]  CCR_RST_PIN_DATA = 5'h00;
  localparam logic [7:0]  CCR_RST_OPFUNC   = 8'h00;
  localparam logic [7:0]  CCR_RST_IMASK    = 8'hFF;
  localparam logic [7:0]  CCR_RST_OPCOND   = 8'h00;
  localparam logic [7:0]  CCR_RST_RT       = 8'h0F;
  localparam logic [15:0] CCR_RST_TX_GAIN  = 16'hA9F0;
  localparam logic [15:0] CCR_RST_RX_GAIN  = 16'h23A1;

  // Fixed default coefficient store, never written by software
  localparam logic [15:0] CCR_ROM_TX_GAIN  = 16'hA9F0;
  localparam logic [15:0] CCR_ROM_RX_GAIN  = 16'h23A1;

endpackage

// ---- core/ccr_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to pclk; output changes only when
// the second and third stages agree.
`timescale 1ns/1ps
module ccr_pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pin side and filtered result
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] stable_q
);

  logic [WIDTH-1:0] meta_q;   // First stage, read only by the second
  logic [WIDTH-1:0] sync2_q;  // Second stage
  logic [WIDTH-1:0] sync3_q;  // Third stage

  // ==========================================================
  // Synchroniser chain
  // ==========================================================
  // Stages reset to the documented idle level to avoid a false change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= RST_VAL;
      sync2_q <= RST_VAL;
      sync3_q <= RST_VAL;
    end else begin
      meta_q  <= pin_in;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // Agreement filter: bit by bit, a change counts once two stages match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= RST_VAL;
    end else begin
      stable_q <= (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
    end
  end

endmodule

// ---- core/ccr_coef_decode.sv ----
// Splits one 16-bit gain coefficient into signs and exponents.
// Assumes byte 1 sits in bits 15:8 and byte 2 in bits 7:0.
`timescale 1ns/1ps
module ccr_coef_decode (
  // Coefficient word
  input  wire logic [15:0] coef,
  // Term k (1..4) at index k-1: negative sign flag and 3-bit exponent
  output logic      [3:0]  sign_neg,
  output logic      [11:0] exponent
);

  // ==========================================================
  // Field split, two sign/exponent pairs per byte
  // ==========================================================
  // Sign bit 0 means +1 and 1 means -1, so the bit is the negative flag
  always_comb begin
    sign_neg[0]     = coef[3];
    exponent[2:0]   = coef[2:0];
    sign_neg[1]     = coef[7];
    exponent[5:3]   = coef[6:4];
    sign_neg[2]     = coef[11];
    exponent[8:6]   = coef[10:8];
    sign_neg[3]     = coef[15];
    exponent[11:9]  = coef[14:12];
  end

endmodule

// ---- tb/ccr_regs_properties.sv ----
// Port checker for the codec control register bank.
// Assumes a single pclk domain; bound from the bench top file.
`timescale 1ns/1ps
module ccr_regs_properties
  import ccr_pkg::*;
(
  // Clock, reset and APB
  input wire logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [CCR_ADDR_W-1:0] paddr,
  // Controls, pins and gains
  input wire logic                  linear_code_select, rx_path_cutoff, balance_filter_enable,
  input wire logic [5:0]            coef_source,
  input wire logic [CCR_NPINS-1:0]  line_io_oe, line_io_out,
  input wire logic [15:0]           tx_gain_applied, rx_gain_applied,
  input wire logic [3:0]            tx_gain_sign_neg,
  input wire logic [11:0]           tx_gain_exponent
);
  // Completed write; controls may only move one edge after it
  wire wr = psel && penable && pwrite && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  a_ready_access: assert property (pready == (psel && penable)) else $error("pready off");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr idle");
  a_bal_cut: assert property (balance_filter_enable != rx_path_cutoff) else $error("bal");
  a_txg_rom: assert property (!coef_source[CCR_BIT_SRC_TXG] |->
    tx_gain_applied == CCR_ROM_TX_GAIN) else $error("tx default");
  a_rxg_rom: assert property (!coef_source[CCR_BIT_SRC_RXG] |->
    rx_gain_applied == CCR_ROM_RX_GAIN) else $error("rx default");
  a_sign_dec: assert property (tx_gain_sign_neg == {tx_gain_applied[15],
    tx_gain_applied[11], tx_gain_applied[7], tx_gain_applied[3]}) else $error("sign");
  a_exp_dec: assert property (tx_gain_exponent == {tx_gain_applied[14:12],
    tx_gain_applied[10:8], tx_gain_applied[6:4], tx_gain_applied[2:0]}) else $error("exp");
  a_oe_write: assert property ($changed(line_io_oe) |->
    $past(wr && paddr == 12'h150)) else $error("oe moved");
  a_out_write: assert property ($changed(line_io_out) |->
    $past(wr && paddr == 12'h148)) else $error("pin data moved");
  a_cfg_write: assert property ($changed({linear_code_select, coef_source}) |->
    $past(wr && paddr == 12'h180)) else $error("coding moved");
endmodule

// ---- tb/ccr_host_model.sv ----
// Host model: APB master issuing register transfers.
// Assumes the slave raises pready; the bench watchdog ends hangs.
`timescale 1ns/1ps
module ccr_host_model (
  // Answer from the slave
  input  wire logic        pclk, pready, pslverr,
  input  wire logic [31:0] prdata,
  // Request to the slave
  output logic             psel, penable, pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    // Released address and data show the inverse, not a stale value
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule

// ---- tb/ccr_regs_tb.sv ----
// Bench for ccr_regs driven through the host model.
// Assumes ccr_pkg is compiled first; pclk 10 MHz, presetn async low.
`timescale 1ns/1ps
module ccr_regs_tb;
  import ccr_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value
  logic pclk = 0, presetn = 0, act = 0, lost = 0, e;
  logic psel, penable, pwrite, pready, pslverr, irq_n, lin, law, bal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] oe, out, ext = '0;
  logic [7:0] rt = 8'h0F, cond;
  logic [5:0] src;
  logic [15:0] txg, rxg;
  logic [3:0] rsn;
  logic [11:0] rex;
  int num_errors = 0, num_checks = 0;
  // Pin level resolved from both parties' drive
  wire logic [4:0] pins = (oe & out) | (~oe & ext);
  always #50 pclk = ~pclk;
  ccr_regs #(.REVISION_CODE(REV)) i_ccr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_io_in(pins), .line_io_out(out),
    .line_io_oe(oe), .rt_in(rt), .irq_n(irq_n), .channel_active_in(act),
    .clock_sync_lost_in(lost), .linear_code_select(lin), .companding_law_select(law),
    .coef_source(src), .tx_path_cutoff(cond[7]), .rx_path_cutoff(cond[6]),
    .balance_filter_enable(bal), .tx_highpass_bypass(cond[5]), .rx_extra_loss(cond[4]),
    .tx_irq_arm(cond[3]), .slot_loopback(cond[2]), .full_digital_loopback(cond[1]),
    .rx_1khz_sig_gen(cond[0]), .tx_gain_applied(txg), .rx_gain_applied(rxg),
    .tx_gain_sign_neg(), .tx_gain_exponent(), .rx_gain_sign_neg(rsn), .rx_gain_exponent(rex));
  ccr_host_model i_ccr_host_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  // ==========================================================
  // Shared compare and bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are looked at on the falling edge, once updates landed
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_ccr_host_model.xfer(1'b1, a, d, q, e);
    @(negedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    i_ccr_host_model.xfer(1'b0, a, '0, q, e);
    chk(q, exp);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    logic [11:0] a [7] = '{12'h150, 12'h180, 12'h1B0, 12'h1C0, 12'h1CC, 12'h200, 12'h208};
    logic [31:0] x [7] = '{0, 0, 32'hFF, 0, REV, 32'hA9F0, 32'h23A1};
    for (int i = 0; i < 7; i++) rd(a[i], x[i]);
    chk({oe, irq_n}, 6'h01);
    $display("reset values done");
  endtask
  task t_ctrl;
    wr(12'h200, 32'h1234);
    wr(12'h208, 32'h5678);
    chk(txg, 32'hA9F0);
    wr(12'h180, 32'hFF);
    chk({lin, law, src, txg}, 24'hFF1234);
    chk({rxg, rsn, rex}, {16'h5678, 16'h1BB8});
    wr(12'h180, 32'h00);
    chk(txg, 32'hA9F0);
    rd(12'h200, 32'h1234);
    wr(12'h1C0, 32'hC0);
    chk({cond, bal}, 9'h180);
    wr(12'h1C0, 32'h3F);
    chk({cond, bal}, 9'h07F);
    rd(12'h1C0, 32'h3F);
    $display("control bits done");
  endtask
  task t_pins;
    @(posedge pclk) {act, lost, ext} <= {2'b11, 5'h0A};
    wr(12'h150, 32'h05);
    wr(12'h148, 32'h1F);
    chk({oe, out}, 10'h0BF);
    rd(12'h148, 32'h0F);
    rd(12'h150, 32'h65);
    $display("pins and status done");
  endtask
  task t_err;
    i_ccr_host_model.xfer(1'b0, 12'hFFC, '0, q, e);
    chk(e, 1);
    chk(q, 0);
    wr(12'h1CC, 32'hFF);
    rd(12'h1CC, REV);
    $display("refusals done");
  endtask
  task t_irq;
    wr(12'h1B0, 32'hFE);
    @(posedge pclk) rt <= 8'h0D;
    repeat (8) @(negedge pclk);
    chk(irq_n, 1);
    @(posedge pclk) rt <= 8'h0C;
    for (int i = 0; i < 10 && irq_n; i++) @(negedge pclk);
    chk(irq_n, 0);
    rd(12'h134, 32'h0C);
    chk(irq_n, 0);
    rd(12'h13C, 32'h0C);
    @(negedge pclk);
    chk(irq_n, 1);
    $display("interrupt done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ctrl;
    t_pins;
    t_err;
    t_irq;
    finish_test;
  end
  // Watchdog well beyond the hundred or so cycles the tests take
  initial begin
    #300000;
    num_errors++;
    finish_test;
  end
endmodule
bind ccr_regs ccr_regs_properties i_ccr_regs_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .linear_code_select(linear_code_select), .rx_path_cutoff(rx_path_cutoff),
  .balance_filter_enable(balance_filter_enable), .coef_source(coef_source),
  .line_io_oe(line_io_oe), .line_io_out(line_io_out), .tx_gain_applied(tx_gain_applied),
  .rx_gain_applied(rx_gain_applied), .tx_gain_sign_neg(tx_gain_sign_neg),
  .tx_gain_exponent(tx_gain_exponent));
